// ### wsr_consts.vh
// Constants for the word serial command responder
`ifndef WSR_CONSTS_VH
`define WSR_CONSTS_VH
// ======================================================
// Command words
`define CMD_CLEAR 16'hFFFF
`define CMD_END_NORMAL 16'hC9FF
`define CMD_ERROR_QUERY 16'hCDFF
`define CMD_READ_PROTOCOL 16'hDFFF
`define CMD_READ_STATUS 16'hCFFF
`define CMD_BYTE_REQUEST 16'hDEFF
`define CMD_BEGIN_MASK 16'hFEFF
`define CMD_BEGIN_VALUE 16'hFCFF
`define CMD_EVENT_MASK 16'hFF00
`define CMD_EVENT_VALUE 16'hAF00
// ======================================================
// Event field
`define EVT_ENABLE_BIT 7
`define EVT_REQUEST_TRUE 7'h7D
// ======================================================
// Response words
`define RSP_END_NORMAL 16'hFFFE
`define RSP_NO_ERROR 16'hFFFF
`define RSP_MULTI_QUERY 16'hFFFD
`define RSP_UNRECOGNIZED 16'hFFFC
// Protocol word: v1.4, E*=0, PI* bit 6 filled in, PH*=1, T*=0, I4*=1,
// I*=0, ELW*=1, LW*=1
`define RSP_PROTOCOL_BASE 16'hFF2B
`define PROTO_INTERRUPTER_BIT 6
`define STATUS_UPPER 9'h1FE
`define STATUS_UNUSED 2'h3
`define IACK_UPPER 8'hFD
`define BYTE_UPPER 7'h7F
`define LINE_FEED 8'h0A
// ======================================================
// Error codes
`define ERR_NONE 2'h0
`define ERR_MULTI 2'h1
`define ERR_UNREC 2'h2
`endif

// ### wsr_sync.v
// Two flop synchroniser for one level
`default_nettype none
module wsr_sync (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_async,
  output reg o_sync
);
  reg meta_reg; // First stage, read only by the second
  // ======================================================
  // Sync stages
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      meta_reg <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule // wsr_sync
`default_nettype wire

// ### wsr_irq_gate.v
// Request True interrupt gating and acknowledge tracking
`include "wsr_consts.vh"
`default_nettype none
module wsr_irq_gate (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_allowed,
  input wire i_request,
  input wire i_clear,
  input wire i_iack,
  input wire i_status_read,
  output reg o_irq,
  output reg o_srq_seen
);
  reg wait_status_reg; // Acked, waiting for status read
  // ======================================================
  // Interrupt line and re-arm
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
      o_srq_seen <= 1'b0;
      wait_status_reg <= 1'b0;
    end else if (i_clear) begin
      // Drop pending interrupt, rearm at once
      o_irq <= 1'b0; // [R4]
      wait_status_reg <= 1'b0;
      o_srq_seen <= 1'b0;
    end else begin
      if (o_irq && i_iack) begin
        o_irq <= 1'b0;
        wait_status_reg <= 1'b1;
        o_srq_seen <= 1'b1;
      end else if (!o_irq && !wait_status_reg && i_allowed && i_request)
        o_irq <= 1'b1; // [R15] [R17] [R19]
      if (wait_status_reg && i_status_read && !(o_irq && i_iack)) begin
        wait_status_reg <= 1'b0; // [R19]
        o_srq_seen <= 1'b0;
      end
    end
  end
endmodule // wsr_irq_gate
`default_nettype wire

// ### wsr_responder.v
// Word serial command responder, top level
// How it works
// [R1] Clear: read-ready low, error flag inactive
// [R2] Control Event bit 7 enables or disables
// [R3] Only event 7D (Request True) is honoured
// [R4] End Normal clears interrupts, disables generation
// [R5] End Normal sets ready flags, error/FHS inactive
// [R6] End Normal disables module receivers
// [R7] End Normal response is FFFE
// [R8] Error Query loads oldest unreported error
// [R9] Codes: FFFF none, FFFD multi, FFFC unknown
// [R10] Reading query answer clears error flag
// [R11] Protocol bits 15..8 all one
// [R12] Protocol bits 7 and 4 zero
// [R13] Protocol bits 5 and 3 one
// [R14] Protocol bit 6 follows interrupt level
// [R15] Interrupt needs level 1-7, Begin Normal
// [R16] Event enables come up enabled
// [R17] Module-specific enable also required
// [R18] IACK word FD then logical address
// [R19] No new interrupt before ack, status read
// [R20] Byte response data in bits 7-0
// [R21] Bit 8 marks line feed end
// [R22] Begin Normal enables interrupt generation
// [R23] Status word: SRQ bit 6, causes 3..0
// [R24] Protocol bit 2 zero, bits 1,0 one
`include "wsr_consts.vh"
`default_nettype none
module wsr_responder (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_cmd_write,
  input wire [15:0] i_cmd_word,
  input wire i_data_read,
  input wire [2:0] i_irq_level,
  input wire [7:0] i_logical_addr,
  input wire i_module_irq_enable,
  input wire i_event_gen_enable,
  input wire i_irq_request,
  input wire [3:0] i_channel_cause,
  input wire i_iack,
  input wire [7:0] i_byte_data,
  input wire i_receivers_on,
  output reg [15:0] o_data_low,
  output reg [15:0] o_iack_word,
  output reg o_irq,
  output reg o_read_ready,
  output reg o_write_ready,
  output reg o_data_in_ready,
  output reg o_error_n,
  output reg fast_handshake_flag_n_out,
  output reg o_receivers_disable
);
  // ======================================================
  // Synchronised pins
  wire [2:0] level_sync; // Interrupt level switch
  wire module_en_sync; // Module-specific enable
  wire recv_on_sync; // Receivers currently on
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_level_sync
      wsr_sync u_sync (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_async(i_irq_level[g]),
        .o_sync(level_sync[g])
      );
    end
  endgenerate
  wsr_sync u_sync_men (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_async(i_module_irq_enable),
    .o_sync(module_en_sync)
  );
  wsr_sync u_sync_rcv (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_async(i_receivers_on),
    .o_sync(recv_on_sync)
  );
  // ======================================================
  // Command decode helpers
  function is_cmd;
    input [15:0] word;
    input [15:0] mask;
    input [15:0] value;
    begin
      is_cmd = ((word & mask) == value);
    end
  endfunction
  wire cmd_clear = i_cmd_write &&
    is_cmd(i_cmd_word, 16'hFFFF, `CMD_CLEAR);
  wire cmd_end = i_cmd_write &&
    is_cmd(i_cmd_word, 16'hFFFF, `CMD_END_NORMAL);
  wire cmd_query = i_cmd_write &&
    is_cmd(i_cmd_word, 16'hFFFF, `CMD_ERROR_QUERY);
  wire cmd_proto = i_cmd_write &&
    is_cmd(i_cmd_word, 16'hFFFF, `CMD_READ_PROTOCOL);
  wire cmd_status = i_cmd_write &&
    is_cmd(i_cmd_word, 16'hFFFF, `CMD_READ_STATUS);
  wire cmd_byte = i_cmd_write &&
    is_cmd(i_cmd_word, 16'hFFFF, `CMD_BYTE_REQUEST);
  wire cmd_begin = i_cmd_write &&
    is_cmd(i_cmd_word, `CMD_BEGIN_MASK, `CMD_BEGIN_VALUE);
  wire cmd_event = i_cmd_write &&
    is_cmd(i_cmd_word, `CMD_EVENT_MASK, `CMD_EVENT_VALUE);
  wire cmd_known = cmd_clear | cmd_end | cmd_query | cmd_proto |
    cmd_status | cmd_byte | cmd_begin | cmd_event;
  wire cmd_unknown = i_cmd_write && !cmd_known;
  // ======================================================
  // State
  reg normal_op_reg; // Begin Normal seen since End Normal
  reg req_true_en_reg; // Request True event enable
  reg [1:0] err_code_reg; // Oldest unreported error
  reg query_pending_reg; // Data low holds a query answer
  reg proto_int_n; // Protocol bit 6 value
  wire srq_seen; // Interrupt asserted and acked
  wire irq_line; // From the gate
  wire irq_allowed;
  // Level nonzero, Begin Normal, both event enables, module enable
  assign irq_allowed = (level_sync != 3'h0) && normal_op_reg &&
    req_true_en_reg && i_event_gen_enable && module_en_sync; // [R15] [R16] [R17]
  // ======================================================
  // Interrupt gate
  wsr_irq_gate u_irq (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_allowed(irq_allowed),
    .i_request(i_irq_request),
    .i_clear(cmd_end),
    .i_iack(i_iack),
    .i_status_read(cmd_status),
    .o_irq(irq_line),
    .o_srq_seen(srq_seen)
  );
  always @* begin
    proto_int_n = (level_sync != 3'h0); // [R14]
  end
  // ======================================================
  // Registered outputs
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
      o_iack_word <= 16'h0000;
    end else begin
      o_irq <= irq_line;
      o_iack_word <= {`IACK_UPPER, i_logical_addr}; // [R18]
    end
  end
  // ======================================================
  // Command execution
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      normal_op_reg <= 1'b0;
      req_true_en_reg <= 1'b1; // [R16]
      err_code_reg <= `ERR_NONE;
      query_pending_reg <= 1'b0;
      o_data_low <= `RSP_NO_ERROR;
      o_read_ready <= 1'b0;
      o_write_ready <= 1'b1;
      o_data_in_ready <= 1'b1;
      o_error_n <= 1'b1;
      fast_handshake_flag_n_out <= 1'b1;
      o_receivers_disable <= 1'b0;
    end else begin
      o_receivers_disable <= 1'b0;
      // Query answer read: error flag back inactive
      if (i_data_read && query_pending_reg) begin
        o_error_n <= 1'b1; // [R10]
        query_pending_reg <= 1'b0;
      end
      if (i_data_read)
        o_read_ready <= 1'b0;
      if (cmd_clear) begin
        o_read_ready <= 1'b0; // [R1]
        o_error_n <= 1'b1;
      end else if (cmd_event) begin
        // Other event codes leave everything alone
        if (i_cmd_word[6:0] == `EVT_REQUEST_TRUE) // [R3]
          req_true_en_reg <= i_cmd_word[`EVT_ENABLE_BIT]; // [R2]
      end else if (cmd_begin) begin
        normal_op_reg <= 1'b1; // [R22]
      end else if (cmd_end) begin
        normal_op_reg <= 1'b0; // [R4]
        o_data_in_ready <= 1'b1; // [R5]
        o_read_ready <= 1'b1;
        o_write_ready <= 1'b1;
        o_error_n <= 1'b1;
        fast_handshake_flag_n_out <= 1'b1;
        o_receivers_disable <= recv_on_sync; // [R6]
        o_data_low <= `RSP_END_NORMAL; // [R7]
      end else if (cmd_query) begin
        // Report oldest error, then forget it
        case (err_code_reg)
          `ERR_MULTI: o_data_low <= `RSP_MULTI_QUERY; // [R8] [R9]
          `ERR_UNREC: o_data_low <= `RSP_UNRECOGNIZED; // [R9]
          default: o_data_low <= `RSP_NO_ERROR; // [R9]
        endcase
        err_code_reg <= `ERR_NONE;
        query_pending_reg <= 1'b1;
        o_read_ready <= 1'b1;
      end else if (cmd_proto) begin
        o_data_low <= `RSP_PROTOCOL_BASE |
          {9'h000, proto_int_n, 6'h00}; // [R11] [R12] [R13] [R14] [R24]
        o_read_ready <= 1'b1;
      end else if (cmd_status) begin
        o_data_low <= {`STATUS_UPPER, srq_seen, `STATUS_UNUSED,
          i_channel_cause}; // [R23]
        o_read_ready <= 1'b1;
      end else if (cmd_byte) begin
        o_data_low <= {`BYTE_UPPER, (i_byte_data == `LINE_FEED),
          i_byte_data}; // [R20] [R21]
        o_read_ready <= 1'b1;
      end else if (cmd_unknown) begin
        // Keep the oldest error; only record if none waiting
        if (err_code_reg == `ERR_NONE)
          err_code_reg <= `ERR_UNREC;
        o_error_n <= 1'b0;
      end
    end
  end
endmodule // wsr_responder
`default_nettype wire

// ### wsr_responder_chk.sv
// Port checker for the word serial responder
`default_nettype none
// ====
// Checker
module wsr_responder_chk (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_cmd_write,
  input wire logic [15:0] i_cmd_word,
  input wire logic [2:0] i_irq_level,
  input wire logic [7:0] i_logical_addr,
  input wire logic i_module_irq_enable,
  input wire logic i_event_gen_enable,
  input wire logic i_iack,
  input wire logic [7:0] i_byte_data,
  input wire logic i_receivers_on,
  input wire logic [15:0] o_data_low,
  input wire logic [15:0] o_iack_word,
  input wire logic o_irq,
  input wire logic o_read_ready,
  input wire logic o_write_ready,
  input wire logic o_data_in_ready,
  input wire logic o_error_n,
  input wire logic fast_handshake_flag_n_out,
  input wire logic o_receivers_disable
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // Command seen this cycle, zero when idle
  wire logic [15:0] cw = i_cmd_write ? i_cmd_word : 16'h0000;
  logic blocked_reg; // Acked, status not yet fetched
  // Track the window where a fresh interrupt is forbidden
  always @(posedge i_core_clk) begin
    if (!i_resetn) blocked_reg <= 1'b0;
    else if (o_irq && i_iack) blocked_reg <= 1'b1;
    else if (cw == 16'hCFFF || cw == 16'hC9FF) blocked_reg <= 1'b0;
  end
  property p_clear;
    cw == 16'hFFFF |=> !o_read_ready && o_error_n;
  endproperty
  a_clear: assert property (p_clear) else $error("clear flags");
  property p_end;
    cw == 16'hC9FF |=> o_data_low == 16'hFFFE && o_read_ready &&
      o_write_ready && o_data_in_ready && o_error_n &&
      fast_handshake_flag_n_out;
  endproperty
  a_end: assert property (p_end) else $error("end flags");
  property p_end_irq;
    cw == 16'hC9FF |-> ##2 !o_irq [*3];
  endproperty
  a_end_irq: assert property (p_end_irq) else $error("end irq");
  property p_recv;
    cw == 16'hC9FF && i_receivers_on |=> o_receivers_disable;
  endproperty
  a_recv: assert property (p_recv) else $error("receivers");
  property p_proto;
    cw == 16'hDFFF |=> o_data_low[15:7] == 9'h1FE &&
      o_data_low[5:0] == 6'h2B;
  endproperty
  a_proto: assert property (p_proto) else $error("proto");
  property p_byte;
    cw == 16'hDEFF |=> o_data_low == {7'h7F,
      $past(i_byte_data) == 8'h0A, $past(i_byte_data)};
  endproperty
  a_byte: assert property (p_byte) else $error("byte");
  property p_iack;
    i_iack |=> o_iack_word == {8'hFD, $past(i_logical_addr)};
  endproperty
  a_iack: assert property (p_iack) else $error("iack word");
  property p_hold;
    blocked_reg |-> !$rose(o_irq);
  endproperty
  a_hold: assert property (p_hold) else $error("early irq");
  property p_gate;
    $rose(o_irq) |-> i_irq_level != 3'h0 && i_module_irq_enable &&
      i_event_gen_enable;
  endproperty
  a_gate: assert property (p_gate) else $error("irq gate");
  c_irq: cover property ($rose(o_irq));
  c_ack: cover property (o_irq && i_iack);
  c_end: cover property (cw == 16'hC9FF);
endmodule // wsr_responder_chk
bind wsr_responder wsr_responder_chk wsr_responder_chk_inst (
  .i_core_clk, .i_resetn, .i_cmd_write, .i_cmd_word, .i_irq_level,
  .i_logical_addr, .i_module_irq_enable, .i_event_gen_enable, .i_iack,
  .i_byte_data, .i_receivers_on, .o_data_low, .o_iack_word, .o_irq,
  .o_read_ready, .o_write_ready, .o_data_in_ready, .o_error_n,
  .fast_handshake_flag_n_out, .o_receivers_disable);
`default_nettype wire

// ### wsr_commander.sv
// Backplane commander model issuing word serial traffic
`default_nettype none
// ====
// Commander
module wsr_commander (
  input wire logic i_core_clk,
  output logic o_cmd_write,
  output logic [15:0] o_cmd_word,
  output logic o_data_read,
  output logic o_iack
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_cmd_write = 1'b0;
    o_cmd_word = 16'h0000;
    o_data_read = 1'b0;
    o_iack = 1'b0;
  end
  // One command word; idle bus shows inverse so stale data never matches
  task send(input logic [15:0] w);
    @(negedge i_core_clk);
    o_cmd_write = 1'b1;
    o_cmd_word = w;
    @(negedge i_core_clk);
    o_cmd_write = 1'b0;
    o_cmd_word = ~w;
  endtask
  // Read of data-low, or acknowledge cycle at our level
  task strobe(input bit ack);
    @(negedge i_core_clk);
    if (ack) o_iack = 1'b1;
    else o_data_read = 1'b1;
    @(negedge i_core_clk);
    o_iack = 1'b0;
    o_data_read = 1'b0;
  endtask
endmodule // wsr_commander
`default_nettype wire

// ### word_serial_command_responder_tb.sv
// Self-checking bench for the word serial responder
`default_nettype none
// ====
// Bench
module word_serial_command_responder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic w, rd, ack, irq, mod_en = 1'b1, req = 1'b0;
  logic evt_en = 1'b1, rcv_on = 1'b1; // Event enable, receivers state
  logic rr, wr, dir, err_n, fhs_n, rdis; // Response flags
  logic [15:0] cmd, dl, iw;
  logic [2:0] lvl = 3'h3;
  logic [7:0] addr, bd;
  logic [3:0] cause;
  int n_errors = 0, samples_checked = 0, cyc = 0, err_q[$];
  always #20 i_core_clk = ~i_core_clk;
  wsr_commander wsr_commander_inst (.i_core_clk, .o_cmd_write(w),
    .o_cmd_word(cmd), .o_data_read(rd), .o_iack(ack));
  wsr_responder wsr_responder_inst (.i_core_clk, .i_resetn,
    .i_cmd_write(w), .i_cmd_word(cmd), .i_data_read(rd),
    .i_irq_level(lvl), .i_logical_addr(addr),
    .i_module_irq_enable(mod_en), .i_event_gen_enable(evt_en),
    .i_irq_request(req), .i_channel_cause(cause), .i_iack(ack),
    .i_byte_data(bd), .i_receivers_on(rcv_on), .o_data_low(dl),
    .o_iack_word(iw), .o_irq(irq), .o_read_ready(rr),
    .o_write_ready(wr), .o_data_in_ready(dir), .o_error_n(err_n),
    .fast_handshake_flag_n_out(fhs_n), .o_receivers_disable(rdis));
  // Hang guard
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      final_report();
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // Send a command and compare data-low with the model's answer
  task cmd_rsp(input logic [15:0] c, input logic [15:0] exp);
    wsr_commander_inst.send(c);
    chk(dl, exp);
  endtask
  task irq_after(input logic exp);
    repeat (5) @(negedge i_core_clk);
    chk({15'h0, irq}, {15'h0, exp});
  endtask
  task final_report();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    void'($urandom(22166));
    addr = 8'($urandom);
    cause = 4'($urandom);
    bd = 8'h00;
    repeat (6) @(negedge i_core_clk);
    i_resetn = 1'b1;
    // Let the two-flop synchronisers see the level switch first
    repeat (3) @(negedge i_core_clk);
    // Protocol word with level nonzero, then zero
    cmd_rsp(16'hDFFF, 16'hFF6B);
    lvl = 3'h0;
    repeat (4) @(negedge i_core_clk);
    cmd_rsp(16'hDFFF, 16'hFF2B);
    lvl = 3'h3;
    // Byte responses, line feed marked in bit 8
    for (int i = 0; i < 4; i++) begin
      bd = (i == 1) ? 8'h0A : 8'($urandom);
      cmd_rsp(16'hDEFF, {7'h7F, bd == 8'h0A, bd});
    end
    // Unknown word queued, then queried, read, queried again
    wsr_commander_inst.send(16'h1234);
    err_q.push_back(16'hFFFC);
    chk({15'h0, err_n}, 16'h0000);
    cmd_rsp(16'hCDFF, 16'(err_q.pop_front()));
    wsr_commander_inst.strobe(1'b0);
    chk({15'h0, err_n}, 16'h0001);
    cmd_rsp(16'hCDFF, err_q.size() ? 16'hFFFC : 16'hFFFF);
    wsr_commander_inst.send(16'hFFFF);
    chk({15'h0, rr}, 16'h0000);
    chk({15'h0, err_n}, 16'h0001);
    // Request gating: event off, foreign code, then on
    req = 1'b1;
    irq_after(1'b0);
    wsr_commander_inst.send(16'hAF7D);
    wsr_commander_inst.send(16'hFCFF);
    irq_after(1'b0);
    wsr_commander_inst.send(16'hAFFC);
    irq_after(1'b0);
    wsr_commander_inst.send(16'hAFFD);
    irq_after(1'b1);
    wsr_commander_inst.strobe(1'b1);
    chk(iw, {8'hFD, addr});
    irq_after(1'b0);
    cmd_rsp(16'hCFFF, {12'hFF7, cause});
    irq_after(1'b1);
    cmd_rsp(16'hC9FF, 16'hFFFE);
    chk({10'h0, rr, wr, dir, err_n, fhs_n, rdis}, 16'h003F);
    irq_after(1'b0);
    mod_en = 1'b0;
    wsr_commander_inst.send(16'hFDFF);
    irq_after(1'b0);
    final_report();
  end
endmodule // word_serial_command_responder_tb
`default_nettype wire
